// ===== indicator_settings_peak_hold.sv
// menu-three settings, display refresh and hold control of the indicator
//
// Operation
// R1: function, zero, zero opens menu three; item presses 5..8 pick settings
// R2: scale division limited to 1..100, edited as three digits
// R3: shown value moves only in whole scale-division steps
// R4: conversions run at a fixed 2000 per second
// R5: rate code 3,2,1,0 gives 25,13,6,3 refreshes per second
// R6: decimal place only positions the point, value unchanged
// R7: excitation bit 1 selects 10 V, 0 selects 2.5 V
// R8: edits take effect only on confirm; old setting stays until then
// R9: function key in the menu returns to the live display
// R10: hold is released by the same source that engaged it
// R11: hold freezes the shown value within 5 ms
// R12: hold release resumes tracking within 5 ms
// R13: release request is held long enough to be seen
// R14: peak mode shows the largest value seen while holding
// R15: refreshes come every N conversions, showing the latest sample
`timescale 1ns/1ps
`default_nettype none
module indicator_settings_peak_hold
   import indicator_pkg::*;
#(
   parameter int CONV_CYC = CONV_CYCLES
) (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic                      ce,
   // front panel keys and hold pin, asynchronous
   input  wire logic                      function_key,
   input  wire logic                      zero_key,
   input  wire logic                      item_key,
   input  wire logic                      up_key,
   input  wire logic                      confirm_key,
   input  wire logic                      ext_hold,
   // conversion path
   output logic                           adc_start,
   input  wire logic signed [VALUE_W-1:0] adc_data,
   input  wire logic                      adc_valid,
   // display path
   output logic signed [VALUE_W-1:0]      shown_value,
   output logic [1:0]                     dp_position,
   output logic                           menu_active,
   output logic [3:0]                     menu_item,
   output logic [11:0]                    edit_digits,
   output logic                           excite_high,
   output logic                           hold_active,
   // axi4-lite slave
   input  wire logic [31:0]               s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [31:0]               s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready
);
   import indicator_pkg::*;

   setting_if link ();

   logic [5:0] pin_level;
   logic [5:0] pin_rise;
   logic       k_func;
   logic       k_zero;
   logic       k_item;
   logic       k_up;
   logic       k_conf;
   logic       ext_level;

   menu_t      state;
   logic [3:0] item;
   logic [6:0] edit_val;
   logic [6:0] div_set;
   logic [1:0] rate_set;
   logic [1:0] dp_set;
   logic       exc_set;
   logic       key_hold;
   logic       hold_prev;
   logic       peak_mode;
   logic signed [VALUE_W-1:0] latest;
   logic signed [VALUE_W-1:0] sample_q;
   logic       wr_take;
   logic       rd_take;

   pin_sync #(
      .W (6)
   ) u_pins (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .d       ({ext_hold, confirm_key, up_key, item_key, zero_key,
                 function_key}),
      .level   (pin_level),
      .rise    (pin_rise)
   );

   assign k_func    = pin_rise[0];
   assign k_zero    = pin_rise[1];
   assign k_item    = pin_rise[2];
   assign k_up      = pin_rise[3];
   assign k_conf    = pin_rise[4];
   assign ext_level = pin_level[5];

   refresh_timer #(
      .CONV_CYC (CONV_CYC)
   ) u_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .t       (link)
   );

   // stored value of the setting behind an item press count
   function automatic logic [6:0] stored_of(input logic [3:0] it);
      case (it)
         ITEM_DIV:  return div_set;
         ITEM_RATE: return {5'h00, rate_set};
         ITEM_DP:   return {5'h00, dp_set};
         ITEM_EXC:  return {6'h00, exc_set};
         default:   return 7'h00;
      endcase
   endfunction

   function automatic logic [6:0] max_of(input logic [3:0] it);
      case (it)
         ITEM_DIV:  return DIV_MAX;
         ITEM_RATE: return RATE_MAX;
         ITEM_DP:   return DP_MAX;
         ITEM_EXC:  return EXC_MAX;
         default:   return 7'h00;
      endcase
   endfunction

   function automatic logic [6:0] min_of(input logic [3:0] it);
      return (it == ITEM_DIV) ? DIV_MIN : 7'h00;
   endfunction

   // menu entry and exit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= MENU_LIVE;
      end else if (ce) begin
         case (state)
            MENU_LIVE: begin
               if (k_func) begin
                  state <= MENU_ENTRY1; // R1
               end
            end
            MENU_ENTRY1: begin
               if (k_zero) begin
                  state <= MENU_ENTRY2;
               end else if (k_func || k_item || k_up || k_conf) begin
                  state <= MENU_LIVE;
               end
            end
            MENU_ENTRY2: begin
               if (k_zero) begin
                  state <= MENU_OPEN; // R1
               end else if (k_func || k_item || k_up || k_conf) begin
                  state <= MENU_LIVE;
               end
            end
            MENU_OPEN: begin
               if (k_func) begin
                  state <= MENU_LIVE; // R9
               end
            end
            default: state <= MENU_LIVE;
         endcase
      end
   end

   // item stepping and value editing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         item     <= ITEM_NONE;
         edit_val <= 7'h00;
      end else if (ce) begin
         if (state != MENU_OPEN || k_func) begin
            item     <= ITEM_NONE;
            edit_val <= 7'h00;
         end else if (k_item) begin
            // presses past the last item wrap back to press count 1
            item     <= (item == ITEM_EXC) ? 4'h1 : item + 4'h1; // R1
            edit_val <= stored_of((item == ITEM_EXC) ? 4'h1 : item + 4'h1);
         end else if (k_up && edit_val < max_of(item)) begin
            edit_val <= edit_val + 7'h01; // R2
         end else if (k_zero && edit_val > min_of(item)) begin
            edit_val <= edit_val - 7'h01; // R2
         end
      end
   end

   // stored settings change only on confirm inside the menu
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_set  <= DIV_RST;
         rate_set <= RATE_RST;
         dp_set   <= DP_RST;
         exc_set  <= EXC_RST;
      end else if (ce && state == MENU_OPEN && k_conf && !k_func) begin
         case (item)
            ITEM_DIV:  div_set  <= edit_val; // R8
            ITEM_RATE: rate_set <= edit_val[1:0]; // R8
            ITEM_DP:   dp_set   <= edit_val[1:0]; // R8
            ITEM_EXC:  exc_set  <= edit_val[0]; // R8
            default:   ;
         endcase
      end
   end

   // panel hold toggles only from the live display; the pin hold is
   // a separate level, so neither source can cancel the other
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         key_hold <= 1'b0;
      end else if (ce && state == MENU_LIVE && k_conf) begin
         key_hold <= ~key_hold; // R10
      end
   end

   assign link.rate          = rate_set; // R5
   assign link.force_refresh = hold_prev & ~hold_active; // R12
   assign adc_start          = link.conv_tick; // R4

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_active <= 1'b0;
         hold_prev   <= 1'b0;
      end else if (ce) begin
         hold_active <= key_hold | ext_level; // R11 R12
         hold_prev   <= hold_active;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latest <= '0;
      end else if (ce && adc_valid) begin
         latest <= adc_data; // R15
      end
   end

   assign sample_q = quantise(adc_data, div_set);

   // shown value: tracks at refresh instants, frozen or peak while held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shown_value <= '0;
      end else if (ce) begin
         if (hold_active) begin
            if (peak_mode && adc_valid && sample_q > shown_value) begin
               shown_value <= sample_q; // R14
            end
         end else if (link.refresh_tick) begin
            shown_value <= quantise(latest, div_set); // R3 R15
         end
      end
   end

   // display-side outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dp_position <= DP_RST;
         excite_high <= EXC_RST;
         menu_active <= 1'b0;
         menu_item   <= ITEM_NONE;
         edit_digits <= 12'h000;
      end else if (ce) begin
         dp_position <= dp_set; // R6
         excite_high <= exc_set; // R7
         menu_active <= (state == MENU_OPEN);
         menu_item   <= item;
         edit_digits <= bcd3(edit_val); // R2
      end
   end

   // axi4-lite write side: address and data taken together
   assign wr_take       = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = wr_take;
   assign s_axi_wready  = wr_take;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (ce) begin
         if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (s_axi_awaddr == ADDR_CTRL) ? RESP_OKAY
                                                        : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         peak_mode <= CTRL_PEAK_RST;
      end else if (ce && wr_take && s_axi_awaddr == ADDR_CTRL
                   && s_axi_wstrb[0]) begin
         peak_mode <= s_axi_wdata[CTRL_PEAK_BIT];
      end
   end

   // axi4-lite read side
   assign rd_take       = s_axi_arvalid & ~s_axi_rvalid;
   assign s_axi_arready = rd_take;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (ce) begin
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            case (s_axi_araddr)
               ADDR_CTRL: s_axi_rdata[CTRL_PEAK_BIT] <= peak_mode;
               ADDR_STATUS: begin
                  s_axi_rdata[ST_HOLD_BIT]    <= hold_active;
                  s_axi_rdata[ST_KEYHOLD_BIT] <= key_hold;
                  s_axi_rdata[ST_EXTHOLD_BIT] <= ext_level;
                  s_axi_rdata[ST_MENU_BIT]    <= (state == MENU_OPEN);
                  s_axi_rdata[ST_ITEM_LSB +: 4] <= item;
               end
               ADDR_SETTINGS: begin
                  s_axi_rdata[SET_DIV_LSB +: 7]  <= div_set;
                  s_axi_rdata[SET_RATE_LSB +: 2] <= rate_set;
                  s_axi_rdata[SET_DP_LSB +: 2]   <= dp_set;
                  s_axi_rdata[SET_EXC_BIT]       <= exc_set;
               end
               ADDR_SHOWN: begin
                  s_axi_rdata <= 32'(shown_value);
               end
               default: s_axi_rresp <= RESP_SLVERR;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // indicator_settings_peak_hold
`default_nettype wire

// ===== indicator_pkg.sv
// constants, types and helpers shared by the indicator settings design
package indicator_pkg;

   localparam int CLK_HZ       = 200_000_000;
   localparam int CONV_PER_SEC = 2000;
   localparam int CONV_CYCLES  = CLK_HZ / CONV_PER_SEC;

   // hold latency bound, microseconds and cycles
   localparam int HOLD_MAX_US  = 5000;
   localparam int HOLD_MAX_CYC = HOLD_MAX_US * (CLK_HZ / 1_000_000);

   localparam int VALUE_W = 20;
   localparam int CNV_W   = 10;

   // display refreshes per second for each rate code
   localparam int RATE_3_HZ = 25;
   localparam int RATE_2_HZ = 13;
   localparam int RATE_1_HZ = 6;
   localparam int RATE_0_HZ = 3;

   // settings range and reset values
   localparam logic [6:0] DIV_MIN  = 7'h01;
   localparam logic [6:0] DIV_MAX  = 7'h64;
   localparam logic [6:0] DIV_RST  = 7'h01;
   localparam logic [1:0] RATE_RST = 2'h3;
   localparam logic [1:0] DP_RST   = 2'h0;
   localparam logic       EXC_RST  = 1'b0;
   localparam logic [6:0] RATE_MAX = 7'h03;
   localparam logic [6:0] DP_MAX   = 7'h03;
   localparam logic [6:0] EXC_MAX  = 7'h01;

   // item-select press counts inside menu three
   localparam logic [3:0] ITEM_NONE = 4'h0;
   localparam logic [3:0] ITEM_DIV  = 4'h5;
   localparam logic [3:0] ITEM_RATE = 4'h6;
   localparam logic [3:0] ITEM_DP   = 4'h7;
   localparam logic [3:0] ITEM_EXC  = 4'h8;

   // register map, byte addresses
   localparam logic [31:0] ADDR_CTRL     = 32'h0000_0000;
   localparam logic [31:0] ADDR_STATUS   = 32'h0000_0004;
   localparam logic [31:0] ADDR_SETTINGS = 32'h0000_0008;
   localparam logic [31:0] ADDR_SHOWN    = 32'h0000_000c;
   localparam int CTRL_PEAK_BIT  = 0;
   localparam logic CTRL_PEAK_RST = 1'b0;
   localparam int SET_DIV_LSB    = 0;
   localparam int SET_RATE_LSB   = 8;
   localparam int SET_DP_LSB     = 12;
   localparam int SET_EXC_BIT    = 16;
   localparam int ST_HOLD_BIT    = 0;
   localparam int ST_KEYHOLD_BIT = 1;
   localparam int ST_EXTHOLD_BIT = 2;
   localparam int ST_MENU_BIT    = 3;
   localparam int ST_ITEM_LSB    = 4;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      MENU_LIVE,
      MENU_ENTRY1,
      MENU_ENTRY2,
      MENU_OPEN
   } menu_t;

   // conversions between refreshes for a rate code
   function automatic logic [CNV_W-1:0] refresh_div(input logic [1:0] rate);
      int hz;
      case (rate)
         2'h3: hz = RATE_3_HZ;
         2'h2: hz = RATE_2_HZ;
         2'h1: hz = RATE_1_HZ;
         default: hz = RATE_0_HZ;
      endcase
      return CNV_W'(CONV_PER_SEC / hz);
   endfunction

   // three bcd digits of 0..127
   function automatic logic [11:0] bcd3(input logic [6:0] v);
      logic [3:0] h;
      logic [3:0] t;
      logic [3:0] u;
      h = 4'(v / 7'd100);
      t = 4'((v % 7'd100) / 7'd10);
      u = 4'(v % 7'd10);
      return {h, t, u};
   endfunction

   // round magnitude down to a whole number of division steps
   function automatic logic signed [VALUE_W-1:0] quantise(
      input logic signed [VALUE_W-1:0] x,
      input logic        [6:0]         d);
      logic [VALUE_W-1:0] mag;
      logic [VALUE_W-1:0] dd;
      mag = x[VALUE_W-1] ? VALUE_W'(-x) : VALUE_W'(x);
      dd  = VALUE_W'(d);
      mag = mag - (mag % dd);
      return x[VALUE_W-1] ? -$signed(mag) : $signed(mag);
   endfunction

endpackage

// ===== setting_if.sv
// link between the menu/display core and the refresh scheduler
`timescale 1ns/1ps
`default_nettype none
interface setting_if;
   logic [1:0] rate;
   logic       force_refresh;
   logic       conv_tick;
   logic       refresh_tick;

   modport core  (output rate, output force_refresh,
                  input conv_tick, input refresh_tick);
   modport timer (input rate, input force_refresh,
                  output conv_tick, output refresh_tick);
endinterface
`default_nettype wire

// ===== pin_sync.sv
// two-flop synchroniser with registered rising-edge pulse per bit
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] level,
   output var  logic [W-1:0] rise
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1   <= '0;
         s2   <= '0;
         s3   <= '0;
         rise <= '0;
      end else if (ce) begin
         s1   <= d;
         s2   <= s1;
         s3   <= s2;
         rise <= s2 & ~s3;
      end
   end

   assign level = s2;
endmodule // pin_sync
`default_nettype wire

// ===== refresh_timer.sv
// fixed-rate conversion strobe and divided display refresh strobe
`timescale 1ns/1ps
`default_nettype none
module refresh_timer
   import indicator_pkg::*;
#(
   parameter int CONV_CYC = CONV_CYCLES
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic ce,
   setting_if.timer  t
);
   localparam int CW = $clog2(CONV_CYC);

   logic [CW-1:0]    cyc;
   logic [CNV_W-1:0] cnv;
   logic             pend;
   logic [CNV_W-1:0] div;

   assign div = refresh_div(t.rate);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cyc         <= '0;
         t.conv_tick <= 1'b0;
      end else if (ce) begin
         t.conv_tick <= (cyc == CW'(CONV_CYC - 1)); // R4
         cyc <= (cyc == CW'(CONV_CYC - 1)) ? '0 : cyc + CW'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnv            <= '0;
         pend           <= 1'b0;
         t.refresh_tick <= 1'b0;
      end else if (ce) begin
         t.refresh_tick <= 1'b0;
         if (t.force_refresh) begin
            pend <= 1'b1;
         end
         if (t.conv_tick) begin
            if (cnv >= div - CNV_W'(1) || pend || t.force_refresh) begin
               t.refresh_tick <= 1'b1; // R15 R5
               cnv            <= '0;
               pend           <= 1'b0;
            end else begin
               cnv <= cnv + CNV_W'(1);
            end
         end
      end
   end
endmodule // refresh_timer
`default_nettype wire

// ===== indicator_chk.sv
// port checks for the indicator settings and hold block
`timescale 1ns/1ps
`default_nettype none
module indicator_chk
   import indicator_pkg::*;
#(
   parameter int CONV_CYC = CONV_CYCLES
) (
   input wire logic                      aclk,
   input wire logic                      aresetn,
   input wire logic                      ce,
   input wire logic                      ext_hold,
   input wire logic                      adc_start,
   input wire logic signed [VALUE_W-1:0] shown_value,
   input wire logic [1:0]                dp_position,
   input wire logic                      menu_active,
   input wire logic [3:0]                menu_item,
   input wire logic                      excite_high,
   input wire logic                      hold_active
);
   import indicator_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !ce);
   logic [31:0] since;
   logic        seen;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         since <= 32'h0;
         seen  <= 1'b0;
      end else if (ce && adc_start) begin
         since <= 32'h0;
         seen  <= 1'b1;
      end else if (ce) begin
         since <= since + 32'h1;
      end
   end
   sequence hold_req;
      $rose(ext_hold);
   endsequence
   sequence held_twice;
      hold_active && $past(hold_active);
   endsequence
   chk_menu_idle: assert property (!menu_active |-> menu_item == ITEM_NONE)
      else $error("item count shown outside menu");
   chk_item_range: assert property (menu_active |-> menu_item <= ITEM_EXC)
      else $error("item count out of range");
   chk_conv_period: assert property (
      adc_start && seen |-> since == CONV_CYC - 1)
      else $error("conversion period wrong");
   chk_conv_due: assert property (seen |-> since < CONV_CYC)
      else $error("conversion start overdue");
   chk_hold_engage: assert property (hold_req |-> ##[1:6] hold_active)
      else $error("hold not engaged in time");
   chk_hold_frozen: assert property (
      held_twice |-> shown_value >= $past(shown_value))
      else $error("held value dropped");
   chk_exc_confirm: assert property (
      $changed(excite_high) |-> menu_active && menu_item == ITEM_EXC)
      else $error("excitation changed outside its item");
   chk_dp_confirm: assert property (
      $changed(dp_position) |-> menu_active && menu_item == ITEM_DP)
      else $error("decimal place changed outside its item");
endmodule // indicator_chk

bind indicator_settings_peak_hold indicator_chk #(.CONV_CYC(CONV_CYC)) chk (
   .aclk, .aresetn, .ce, .ext_hold, .adc_start, .shown_value, .dp_position,
   .menu_active, .menu_item, .excite_high, .hold_active);
`default_nettype wire

// ===== panel_model.sv
// front panel keys and external hold pin
`timescale 1ns/1ps
`default_nettype none
module panel_model (
   input  wire logic       aclk,
   output var  logic [4:0] keys,
   output var  logic       ext_hold
);
   initial begin
      keys     = 5'h00;
      ext_hold = 1'b0;
   end
   // one key at a time, 4 cycles down then 4 released
   task automatic press(input int k);
      @(posedge aclk);
      keys[k] <= 1'b1;
      repeat (4) @(posedge aclk);
      keys[k] <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask
   task automatic set_hold(input logic v);
      @(posedge aclk);
      ext_hold <= v;
      repeat (40) @(posedge aclk);
   endtask
endmodule // panel_model
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for menu settings, refresh and hold
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import indicator_pkg::*;
   localparam int CC = 20;
   logic                      aclk = 1'b0;
   logic                      aresetn = 1'b0;
   logic [4:0]                keys;
   logic                      ext_hold, adc_start, menu_active;
   logic                      excite_high, hold_active;
   logic                      adc_valid = 1'b0;
   logic signed [VALUE_W-1:0] adc_data = '0;
   logic signed [VALUE_W-1:0] shown_value;
   logic [1:0]                dp_position, s_axi_bresp, s_axi_rresp;
   logic [3:0]                menu_item;
   logic [11:0]               edit_digits;
   logic [31:0]               s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0]               s_axi_wdata = '0, s_axi_rdata;
   logic                      s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic                      s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic                      s_axi_bready = 1'b0, s_axi_awready;
   logic                      s_axi_wready, s_axi_bvalid;
   logic                      s_axi_arready, s_axi_rvalid;
   int                        num_errors = 0, compares = 0;
   int                        cycles = 0, adc_val = 0;
   logic                      ce = 1'b1;
   logic [3:0]                wstrb = 4'hf;

   indicator_settings_peak_hold #(.CONV_CYC(CC)) dut (
      .aclk, .aresetn, .ce, .function_key(keys[0]),
      .zero_key(keys[1]), .item_key(keys[2]), .up_key(keys[3]),
      .confirm_key(keys[4]), .ext_hold, .adc_start, .adc_data, .adc_valid,
      .shown_value, .dp_position, .menu_active, .menu_item, .edit_digits,
      .excite_high, .hold_active, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(wstrb), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   panel_model panel (.aclk, .keys, .ext_hold);

   always #2.5 aclk = ~aclk;

   // converter answer; the data lines toggle outside valid
   always @(posedge aclk) begin
      adc_valid <= adc_start;
      adc_data  <= adc_start ? VALUE_W'(adc_val) : ~adc_data;
      cycles = cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do @(posedge aclk); while (!(s_axi_awready === 1'b1 &&
                                   s_axi_wready === 1'b1));
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid  <= 1'b0;
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      chk(s_axi_bresp, er);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
      s_axi_rready <= 1'b0;
   endtask

   // open menu three and step the item key n times
   task automatic menu(input int n);
      panel.press(0);
      panel.press(1);
      panel.press(1);
      repeat (n) panel.press(2);
   endtask

   task automatic wait_shown(input int exp);
      int n = 0;
      while (shown_value !== VALUE_W'(exp) && n < 2000) begin
         @(posedge aclk);
         n++;
      end
      chk(shown_value, exp);
   endtask

   task automatic t_regs();
      rd(ADDR_SETTINGS, 32'h0000_0301, RESP_OKAY);
      rd(32'h0000_0010, 32'h0, RESP_SLVERR);
      wr(ADDR_STATUS, 32'h1, RESP_SLVERR);
      wr(ADDR_CTRL, 32'h1, RESP_OKAY);
      rd(ADDR_CTRL, 32'h1, RESP_OKAY);
      wstrb <= 4'he;
      wr(ADDR_CTRL, 32'h0, RESP_OKAY);
      rd(ADDR_CTRL, 32'h1, RESP_OKAY);
      wstrb <= 4'hf;
      wr(ADDR_CTRL, 32'h0, RESP_OKAY);
      $display("registers done");
   endtask

   task automatic t_menu();
      menu(5);
      chk(menu_active, 1'b1);
      chk(menu_item, ITEM_DIV);
      panel.press(1);
      chk(edit_digits, 12'h001);
      repeat (100) panel.press(3);
      chk(edit_digits, 12'h100);
      rd(ADDR_SETTINGS, 32'h0000_0301, RESP_OKAY);
      panel.press(4);
      rd(ADDR_SETTINGS, 32'h0000_0364, RESP_OKAY);
      repeat (3) panel.press(2);
      chk(menu_item, ITEM_EXC);
      panel.press(3);
      panel.press(0);
      chk(menu_active, 1'b0);
      chk(excite_high, 1'b0);
      menu(8);
      panel.press(3);
      panel.press(4);
      chk(excite_high, 1'b1);
      panel.press(0);
      menu(7);
      repeat (2) panel.press(3);
      panel.press(4);
      chk(dp_position, 2'h2);
      panel.press(0);
      menu(6);
      for (int i = 2; i >= 0; i--) begin
         panel.press(1);
         panel.press(4);
         rd(ADDR_SETTINGS, 32'h0001_2064 | (32'(i) << 8), RESP_OKAY);
      end
      repeat (3) panel.press(3);
      panel.press(4);
      panel.press(0);
      rd(ADDR_SETTINGS, 32'h0001_2364, RESP_OKAY);
      $display("menu done");
   endtask

   task automatic t_refresh();
      adc_val = 12345;
      wait_shown(12300);
      ce <= 1'b0;
      panel.press(4);
      ce <= 1'b1;
      chk(hold_active, 1'b0);
      $display("refresh done");
   endtask

   task automatic t_hold();
      panel.set_hold(1'b1);
      chk(hold_active, 1'b1);
      adc_val = 23456;
      repeat (1800) @(posedge aclk);
      chk(shown_value, 12300);
      panel.set_hold(1'b0);
      chk(shown_value, 23400);
      panel.press(4);
      chk(hold_active, 1'b1);
      panel.set_hold(1'b1);
      panel.set_hold(1'b0);
      chk(hold_active, 1'b1);
      panel.press(4);
      chk(hold_active, 1'b0);
      wr(ADDR_CTRL, 32'h1, RESP_OKAY);
      panel.set_hold(1'b1);
      adc_val = 34567;
      wait_shown(34500);
      adc_val = 1000;
      repeat (100) @(posedge aclk);
      chk(shown_value, 34500);
      panel.set_hold(1'b0);
      wr(ADDR_CTRL, 32'h0, RESP_OKAY);
      wait_shown(1000);
      $display("hold done");
   endtask

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      t_regs();
      t_menu();
      t_refresh();
      t_hold();
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
